// ==== bench/timer16_irq_flag_mask_test.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
// ==========
// bench top
module timer16_irq_flag_mask_test
	import tmrirq_pkg::*;
;
	logic          clk_sys_i = 0, arst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic          pin = 0, glb = 0, hit = 0, en = 0, pready, pslverr, err;
	logic [11:0]   paddr = 0;
	logic [31:0]   pwdata = 0, prdata, rd;
	logic [3:0]    lat = 0;
	tmrirq_timer_t tm = '0;
	tmrirq_vec_t   tk1, tk3, rq1, rq3;
	int            fails = 0, n_checks = 0;
	localparam logic [11:0] F1 = {UNIT1_FLAGS_IDX, 2'b00}, M1 = {UNIT1_MASK_IDX, 2'b00};
	localparam logic [11:0] F3 = {UNIT3_FLAGS_IDX, 2'b00}, M3 = {UNIT3_MASK_IDX, 2'b00};
	localparam logic [11:0] RA[4] = '{F1, M1, F3, M3};
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	// both units see one stimulus, so each check but the race one covers the pair
	tmrirq_top u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .unit1_timer_i(tm), .unit3_timer_i(tm), .unit1_capture_pin_i(pin),
		.unit3_capture_pin_i(pin), .global_int_enable_i(glb), .unit1_vector_taken_i(tk1),
		.unit3_vector_taken_i(tk3), .unit1_request_o(rq1), .unit3_request_o(rq3));
	tmrirq_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .en_i(en), .lat_i(lat),
		.req1_i(rq1), .req3_i(rq3), .taken1_o(tk1), .taken3_o(tk3));
	// ==========
	// tasks
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_sys_i);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
		@(posedge clk_sys_i);
		penable <= 1; tm.wrap <= hit;
		do @(posedge clk_sys_i); while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 0; penable <= 0; tm.wrap <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1, a, d, rd, err);
	endtask
	task rdc(input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 8'h00, rd, err);
		`CHK("rdata", {24'h0, e}, rd)
	endtask
	task ev;
		@(posedge clk_sys_i);
		tm.counter <= 16'h0005; tm.tick <= 1; tm.wrap <= 1; pin <= 1;
		@(posedge clk_sys_i);
		tm.counter <= 16'h0006; tm.wrap <= 0;
		@(posedge clk_sys_i);
		tm.tick <= 0; pin <= 0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	task done(input string s);
		$display("test %s done", s);
	endtask
	task summarize;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		tm.compare_a <= 16'h0005; tm.compare_b <= 16'h0005;
		repeat (6) @(posedge clk_sys_i);
		arst_n_i <= 1;
		foreach (RA[i]) rdc(RA[i], 8'h00);
		apb(0, 12'hFFC, 8'h00, rd, err);
		`CHK("unmapped", 33'h1_0000_0000, {err, rd})
		done("reset");
		wr(M1, 8'hFF); wr(M3, 8'hFF);
		rdc(M1, 8'h27);
		rdc(M3, 8'h27);
		glb <= 1; ev;
		rdc(F1, 8'h27);
		rdc(F3, 8'h27);
		`CHK("req", 8'hFF, {rq1, rq3})
		glb <= 0; repeat (2) @(posedge clk_sys_i);
		`CHK("req off", 8'h00, {rq1, rq3})
		glb <= 1; done("set");
		wr(F1, 8'h00); rdc(F1, 8'h27);
		wr(F1, 8'h01); rdc(F1, 8'h26);
		wr(F3, 8'h01); rdc(F3, 8'h26);
		wr(F1, 8'h26); rdc(F1, 8'h00);
		wr(F3, 8'hFF); rdc(F3, 8'h00);
		done("w1c");
		tm.mode <= MODE_PFC_CAPTOP; tm.top <= 1;
		@(posedge clk_sys_i) tm.top <= 0;
		rdc(F1, 8'h20);
		rdc(F3, 8'h20);
		wr(F1, 8'hFF); wr(F3, 8'hFF);
		done("captop");
		// fast modes count overflow at top, phase correct ones at bottom
		tm.mode <= MODE_FAST_8BIT; tm.top <= 1;
		@(posedge clk_sys_i) tm.top <= 0;
		rdc(F1, 8'h01);
		rdc(F3, 8'h01);
		wr(F1, 8'hFF); wr(F3, 8'hFF); tm.mode <= MODE_PC_8BIT; tm.bottom <= 1;
		@(posedge clk_sys_i) tm.bottom <= 0;
		rdc(F1, 8'h01);
		rdc(F3, 8'h01);
		wr(F1, 8'hFF); wr(F3, 8'hFF); tm.mode <= MODE_NORMAL;
		done("overflow source");
		hit <= 1; wr(F1, 8'h01); hit <= 0;
		rdc(F1, 8'h01);
		wr(F1, 8'h01); wr(F3, 8'h01);
		done("race");
		// prompt then slow vector service
		for (int i = 0; i < 2; i++) begin
			lat <= 4'(i * 5); en <= 1; ev;
			repeat (80) @(posedge clk_sys_i);
			rdc(F1, 8'h00);
			rdc(F3, 8'h00);
		end
		en <= 0; done("vector");
		summarize;
	end
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		fails++;
		summarize;
	end
endmodule

// ==== bench/tmrirq_chk.sv ====
`timescale 1ns/10ps
// ==========
// port checker
module tmrirq_chk
	import tmrirq_pkg::*;
(
	input logic              clk_sys_i,
	input logic              arst_n_i,
	input logic              psel_i,
	input logic              penable_i,
	input logic              pwrite_i,
	input logic [ADDR_W-1:0] paddr_i,
	input logic [31:0]       pwdata_i,
	input logic [31:0]       prdata_o,
	input tmrirq_timer_t     unit1_timer_i,
	input logic              global_int_enable_i,
	input tmrirq_vec_t       unit1_vector_taken_i,
	input tmrirq_vec_t       unit1_request_o,
	input tmrirq_vec_t       unit3_request_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	property p_req1_ovf; unit1_request_o.overflow |-> global_int_enable_i; endproperty
	a_req1_ovf: assert property (p_req1_ovf)
		else $error("unit1 overflow request without global enable");
	property p_req3_cap; $fell(global_int_enable_i) |-> !unit3_request_o.capture; endproperty
	a_req3_cap: assert property (p_req3_cap)
		else $error("unit3 capture request kept after global disable");
	property p_req3_cmpb; !global_int_enable_i [*2] |-> !unit3_request_o.compare_b; endproperty
	a_req3_cmpb: assert property (p_req3_cmpb)
		else $error("unit3 compare b request while disabled");
	property p_req3_cmpa; global_int_enable_i || !unit3_request_o.compare_a; endproperty
	a_req3_cmpa: assert property (p_req3_cmpa)
		else $error("unit3 compare a request while disabled");
	property p_req3_ovf; !global_int_enable_i |-> 4'(unit3_request_o) == 4'h0; endproperty
	a_req3_ovf: assert property (p_req3_ovf)
		else $error("unit3 request while disabled");
	property p_rsvd; psel_i && penable_i && !pwrite_i |-> prdata_o[31:8] == 24'h0 && prdata_o[7:6] == 2'h0
		&& prdata_o[4:3] == 2'h0; endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved read bits not zero");
	property p_vec_clr; unit1_vector_taken_i.overflow && !unit1_timer_i.wrap && !unit1_timer_i.top
		&& !unit1_timer_i.bottom |=> !unit1_request_o.overflow; endproperty
	a_vec_clr: assert property (p_vec_clr)
		else $error("unit1 overflow not cleared by vector");
	property p_w0; psel_i && penable_i && pwrite_i && paddr_i == {UNIT1_FLAGS_IDX, 2'b00}
		&& !pwdata_i[OVERFLOW_BIT] && unit1_request_o.overflow && !unit1_vector_taken_i.overflow
		|=> unit1_request_o.overflow || !global_int_enable_i; endproperty
	a_w0: assert property (p_w0)
		else $error("writing zero cleared unit1 overflow");
endmodule
bind tmrirq_top tmrirq_chk u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.unit1_timer_i(unit1_timer_i), .global_int_enable_i(global_int_enable_i),
	.unit1_vector_taken_i(unit1_vector_taken_i), .unit1_request_o(unit1_request_o),
	.unit3_request_o(unit3_request_o));

// ==== bench/tmrirq_cpu_model.sv ====
`timescale 1ns/10ps
// ==========
// cpu vector model
module tmrirq_cpu_model
	import tmrirq_pkg::*;
(
	// clock and reset
	input  logic        clk_sys_i,
	input  logic        arst_n_i,
	// control
	input  logic        en_i,
	input  logic [3:0]  lat_i,
	// requests and vectors
	input  tmrirq_vec_t req1_i,
	input  tmrirq_vec_t req3_i,
	output tmrirq_vec_t taken1_o,
	output tmrirq_vec_t taken3_o
);
	logic [3:0] cnt;
	// one vector at a time, lowest bit first; a pause after each lets the request drop
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= 4'h0;
			taken1_o <= '0;
			taken3_o <= '0;
		end else begin
			taken1_o <= '0;
			taken3_o <= '0;
			if (!en_i || (taken1_o | taken3_o) != 4'h0 || (req1_i | req3_i) == 4'h0) begin
				cnt <= 4'h0;
			end else if (cnt < lat_i) begin
				cnt <= cnt + 4'h1;
			end else begin
				cnt <= 4'h0;
				if (req1_i != 4'h0) begin
					taken1_o <= 4'(req1_i) & (4'h0 - 4'(req1_i));
				end else begin
					taken3_o <= 4'(req3_i) & (4'h0 - 4'(req3_i));
				end
			end
		end
	end
endmodule

// ==== src/tmrirq_pkg.sv ====
package tmrirq_pkg;

	// ==============================
	// register indices (byte address = index * 4)
	localparam logic [9:0] UNIT1_FLAGS_IDX = 10'h016;
	localparam logic [9:0] UNIT1_MASK_IDX  = 10'h06F;
	localparam logic [9:0] UNIT3_FLAGS_IDX = 10'h018;
	localparam logic [9:0] UNIT3_MASK_IDX  = 10'h070;
	localparam int         ADDR_W          = 12;

	// ==============================
	// field positions and reset values
	localparam int         CAPTURE_BIT   = 5;
	localparam int         COMPARE_B_BIT = 2;
	localparam int         COMPARE_A_BIT = 1;
	localparam int         OVERFLOW_BIT  = 0;
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [3:0] VEC_RESET     = 4'h0;
	localparam logic [2:0] SYNC_RESET    = 3'h0;

	// ==============================
	// waveform mode codes
	localparam logic [3:0] MODE_NORMAL      = 4'h0;
	localparam logic [3:0] MODE_PC_8BIT     = 4'h1;
	localparam logic [3:0] MODE_PC_9BIT     = 4'h2;
	localparam logic [3:0] MODE_PC_10BIT    = 4'h3;
	localparam logic [3:0] MODE_CLR_CMPA    = 4'h4;
	localparam logic [3:0] MODE_FAST_8BIT   = 4'h5;
	localparam logic [3:0] MODE_FAST_9BIT   = 4'h6;
	localparam logic [3:0] MODE_FAST_10BIT  = 4'h7;
	localparam logic [3:0] MODE_PFC_CAPTOP  = 4'h8;
	localparam logic [3:0] MODE_PFC_CMPTOP  = 4'h9;
	localparam logic [3:0] MODE_PC_CAPTOP   = 4'hA;
	localparam logic [3:0] MODE_PC_CMPTOP   = 4'hB;
	localparam logic [3:0] MODE_CLR_CAP     = 4'hC;
	localparam logic [3:0] MODE_FAST_CAPTOP = 4'hE;
	localparam logic [3:0] MODE_FAST_CMPTOP = 4'hF;

	// ==============================
	// carriers
	typedef struct packed {
		logic capture;
		logic compare_b;
		logic compare_a;
		logic overflow;
	} tmrirq_vec_t;

	typedef struct packed {
		logic [15:0] counter;
		logic [15:0] compare_a;
		logic [15:0] compare_b;
		logic        tick;
		logic        wrap;
		logic        top;
		logic        bottom;
		logic [3:0]  mode;
	} tmrirq_timer_t;

endpackage

// ==== src/tmrirq_top.sv ====
// Operation
// - unit1 overflow request needs enable, global, flag
// - unit3 capture request needs enable, global, flag
// - unit3 compare B request needs enable, global, flag
// - unit3 compare A request needs enable, global, flag
// - unit3 overflow request needs enable, global, flag
// - reserved bits 7:6 and 4:3 read zero
// - unit1 capture pin event sets capture flag
// - capture-as-top mode sets capture flag at top
// - unit1 capture flag cleared by vector or one
// - unit1 compare B flag set tick after match
// - unit1 forced compare never sets flags
// - unit1 compare A flag set tick after match
// - unit1 compare flags cleared by vector or one
// - unit1 overflow flag set per waveform mode
// - unit1 overflow flag cleared by vector or one
// - unit3 capture flag set by pin, or by top in capture-as-top modes
// - unit3 capture flag cleared by vector or one
// - unit3 compare flags set tick after match
// - unit3 forced compare leaves flags unchanged
// - unit3 compare flags cleared by vector or one
// - unit3 overflow flag set per waveform mode
// - unit3 overflow flag cleared by vector or one
// - unit1 capture/compare requests gated by mask, global
`timescale 1ns/10ps

module tmrirq_unit
	import tmrirq_pkg::*;
(
	// clock and reset
	input  logic          clk_sys_i,
	input  logic          arst_n_i,
	// timer datapath
	input  tmrirq_timer_t timer_i,
	input  logic          capture_pin_i,
	// cpu side
	input  logic          global_int_enable_i,
	input  tmrirq_vec_t   vector_taken_i,
	input  logic          mask_write_i,
	input  logic          flag_write_i,
	input  logic [7:0]    wdata_i,
	// state out
	output tmrirq_vec_t   mask_o,
	output tmrirq_vec_t   flags_o,
	output tmrirq_vec_t   request_o
);

	// ==============================
	// state
	typedef struct packed {
		tmrirq_vec_t mask;
		tmrirq_vec_t flags;
		logic [2:0]  capture_sync;
		logic        match_a;
		logic        match_b;
	} tmrirq_unit_state_t;

	tmrirq_unit_state_t state;
	tmrirq_unit_state_t next_state;

	tmrirq_vec_t set_evt;
	tmrirq_vec_t clr_evt;
	logic        capture_edge;
	logic        capture_is_top;
	logic        overflow_evt;

	// ==============================
	// event decode
	// sync stage 0 only feeds the next stage; edge uses 1 and 2
	assign capture_edge = state.capture_sync[1] & ~state.capture_sync[2];

	always_comb begin
		case (timer_i.mode)
			MODE_PFC_CAPTOP,
			MODE_PC_CAPTOP,
			MODE_CLR_CAP,
			MODE_FAST_CAPTOP: capture_is_top = 1'b1;
			default:          capture_is_top = 1'b0;
		endcase
	end

	// overflow source follows the counting sequence of the mode
	always_comb begin
		case (timer_i.mode)
			MODE_NORMAL,
			MODE_CLR_CMPA,
			MODE_CLR_CAP:     overflow_evt = timer_i.wrap;
			MODE_FAST_8BIT,
			MODE_FAST_9BIT,
			MODE_FAST_10BIT,
			MODE_FAST_CAPTOP,
			MODE_FAST_CMPTOP: overflow_evt = timer_i.top;
			MODE_PC_8BIT,
			MODE_PC_9BIT,
			MODE_PC_10BIT,
			MODE_PFC_CAPTOP,
			MODE_PFC_CMPTOP,
			MODE_PC_CAPTOP,
			MODE_PC_CMPTOP:   overflow_evt = timer_i.bottom;
			default:          overflow_evt = 1'b0;
		endcase
	end

	always_comb begin
		// a forced compare strobe has no path into the match terms
		set_evt.capture   = capture_edge | (capture_is_top & timer_i.top);
		set_evt.compare_b = timer_i.tick & state.match_b;
		set_evt.compare_a = timer_i.tick & state.match_a;
		set_evt.overflow  = overflow_evt;
		// write-one clear; zeros leave flags alone
		clr_evt.capture   = vector_taken_i.capture   | (flag_write_i & wdata_i[CAPTURE_BIT]);
		clr_evt.compare_b = vector_taken_i.compare_b | (flag_write_i & wdata_i[COMPARE_B_BIT]);
		clr_evt.compare_a = vector_taken_i.compare_a | (flag_write_i & wdata_i[COMPARE_A_BIT]);
		clr_evt.overflow  = vector_taken_i.overflow  | (flag_write_i & wdata_i[OVERFLOW_BIT]);
	end

	// ==============================
	// next state
	always_comb begin
		next_state              = state;
		next_state.capture_sync = {state.capture_sync[1:0], capture_pin_i};
		// match seen on one timer tick raises the flag on the next
		if (timer_i.tick) begin
			next_state.match_a = (timer_i.counter == timer_i.compare_a);
			next_state.match_b = (timer_i.counter == timer_i.compare_b);
		end
		if (mask_write_i) begin
			next_state.mask.capture   = wdata_i[CAPTURE_BIT];
			next_state.mask.compare_b = wdata_i[COMPARE_B_BIT];
			next_state.mask.compare_a = wdata_i[COMPARE_A_BIT];
			next_state.mask.overflow  = wdata_i[OVERFLOW_BIT];
		end
		next_state.flags = (state.flags & ~clr_evt) | set_evt;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state.mask         <= VEC_RESET;
			state.flags        <= VEC_RESET;
			state.capture_sync <= SYNC_RESET;
			state.match_a      <= 1'b0;
			state.match_b      <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ==============================
	// outputs
	assign mask_o    = state.mask;
	assign flags_o   = state.flags;
	// global enable gated after the flops, so dropping it masks requests at once
	assign request_o = state.flags & state.mask & {4{global_int_enable_i}};

endmodule

// ==============================
// one register index comparator per mapped register
module tmrirq_addr_match
	import tmrirq_pkg::*;
#(
	parameter logic [9:0] INDEX = 10'h000
)
(
	// decoded word index
	input  logic [9:0] index_i,
	// match
	output logic       hit_o
);

	assign hit_o = (index_i == INDEX);

endmodule

// ==============================
// register byte image; unimplemented bits always read zero
module tmrirq_pack
	import tmrirq_pkg::*;
(
	// register bits
	input  tmrirq_vec_t vec_i,
	// byte image
	output logic [7:0]  byte_o
);

	always_comb begin
		byte_o                = REG_RESET;
		byte_o[CAPTURE_BIT]   = vec_i.capture;
		byte_o[COMPARE_B_BIT] = vec_i.compare_b;
		byte_o[COMPARE_A_BIT] = vec_i.compare_a;
		byte_o[OVERFLOW_BIT]  = vec_i.overflow;
	end

endmodule

module tmrirq_top
	import tmrirq_pkg::*;
(
	// clock and reset
	input  logic              clk_sys_i,
	input  logic              arst_n_i,
	// apb slave
	input  logic              psel_i,
	input  logic              penable_i,
	input  logic              pwrite_i,
	input  logic [ADDR_W-1:0] paddr_i,
	input  logic [31:0]       pwdata_i,
	output logic [31:0]       prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	// timer datapaths
	input  tmrirq_timer_t     unit1_timer_i,
	input  tmrirq_timer_t     unit3_timer_i,
	input  logic              unit1_capture_pin_i,
	input  logic              unit3_capture_pin_i,
	// cpu interrupt logic
	input  logic              global_int_enable_i,
	input  tmrirq_vec_t       unit1_vector_taken_i,
	input  tmrirq_vec_t       unit3_vector_taken_i,
	output tmrirq_vec_t       unit1_request_o,
	output tmrirq_vec_t       unit3_request_o
);

	// ==============================
	// state
	typedef struct packed {
		logic [7:0] rdata;
		logic       err;
	} tmrirq_bus_state_t;

	tmrirq_bus_state_t state;
	tmrirq_bus_state_t next_state;

	logic [9:0]  reg_idx;
	logic        hit_m1;
	logic        hit_f1;
	logic        hit_m3;
	logic        hit_f3;
	logic        hit;
	logic        wr_access;
	tmrirq_vec_t mask1;
	tmrirq_vec_t flags1;
	tmrirq_vec_t mask3;
	tmrirq_vec_t flags3;
	logic [7:0]  image_m1;
	logic [7:0]  image_f1;
	logic [7:0]  image_m3;
	logic [7:0]  image_f3;

	// ==============================
	// address decode
	// address bits 1:0 are ignored; each register owns one word
	assign reg_idx   = paddr_i[11:2];

	tmrirq_addr_match #(
		.INDEX (UNIT1_MASK_IDX)
	) u_hit_m1 (
		.index_i (reg_idx),
		.hit_o   (hit_m1)
	);

	tmrirq_addr_match #(
		.INDEX (UNIT1_FLAGS_IDX)
	) u_hit_f1 (
		.index_i (reg_idx),
		.hit_o   (hit_f1)
	);

	tmrirq_addr_match #(
		.INDEX (UNIT3_MASK_IDX)
	) u_hit_m3 (
		.index_i (reg_idx),
		.hit_o   (hit_m3)
	);

	tmrirq_addr_match #(
		.INDEX (UNIT3_FLAGS_IDX)
	) u_hit_f3 (
		.index_i (reg_idx),
		.hit_o   (hit_f3)
	);

	assign hit       = hit_m1 | hit_f1 | hit_m3 | hit_f3;
	assign wr_access = psel_i & penable_i & pwrite_i;

	// ==============================
	// units
	tmrirq_unit u_unit1 (
		.clk_sys_i           (clk_sys_i),
		.arst_n_i            (arst_n_i),
		.timer_i             (unit1_timer_i),
		.capture_pin_i       (unit1_capture_pin_i),
		.global_int_enable_i (global_int_enable_i),
		.vector_taken_i      (unit1_vector_taken_i),
		.mask_write_i        (wr_access & hit_m1),
		.flag_write_i        (wr_access & hit_f1),
		.wdata_i             (pwdata_i[7:0]),
		.mask_o              (mask1),
		.flags_o             (flags1),
		.request_o           (unit1_request_o)
	);

	tmrirq_unit u_unit3 (
		.clk_sys_i           (clk_sys_i),
		.arst_n_i            (arst_n_i),
		.timer_i             (unit3_timer_i),
		.capture_pin_i       (unit3_capture_pin_i),
		.global_int_enable_i (global_int_enable_i),
		.vector_taken_i      (unit3_vector_taken_i),
		.mask_write_i        (wr_access & hit_m3),
		.flag_write_i        (wr_access & hit_f3),
		.wdata_i             (pwdata_i[7:0]),
		.mask_o              (mask3),
		.flags_o             (flags3),
		.request_o           (unit3_request_o)
	);

	// ==============================
	// read path, captured in the setup cycle so prdata is a flop
	tmrirq_pack u_pack_m1 (
		.vec_i  (mask1),
		.byte_o (image_m1)
	);

	tmrirq_pack u_pack_f1 (
		.vec_i  (flags1),
		.byte_o (image_f1)
	);

	tmrirq_pack u_pack_m3 (
		.vec_i  (mask3),
		.byte_o (image_m3)
	);

	tmrirq_pack u_pack_f3 (
		.vec_i  (flags3),
		.byte_o (image_f3)
	);

	always_comb begin
		next_state = state;
		if (psel_i && !penable_i) begin
			next_state.err = ~hit;
			if (hit_m1) begin
				next_state.rdata = image_m1;
			end else if (hit_f1) begin
				next_state.rdata = image_f1;
			end else if (hit_m3) begin
				next_state.rdata = image_m3;
			end else if (hit_f3) begin
				next_state.rdata = image_f3;
			end else begin
				next_state.rdata = REG_RESET;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state.rdata <= REG_RESET;
			state.err   <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ==============================
	// bus outputs; no wait states
	assign prdata_o  = {24'h000000, state.rdata};
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & state.err;

endmodule
